/* File: rtl/psr_pkg.sv */
// Purpose: Constants and carrier types for the paged special register space
// Assumes: 8-bit data, 6-bit direct address, core-driven access strobes
// Notes: Register offsets are direct addresses; pages select among aliases
// Behaviour
// RULE1: Addresses 00-0F decode as special registers across four distinct pages.
// RULE2: Addresses 10-1F are one global RAM; bank bits ignored there.
// RULE3: Addresses 20-3F select one of four 32-byte banks; software sets bank first.
// RULE4: Control registers reached only by dedicated control-space read and write.
// RULE5: Port 7 bit 0 edge raises interrupt; counter control selects polarity.
// RULE6: Falling edges on port 7 bits 1 and 3 set one shared flag.
// RULE7: Port 7 bit 1 is input only, no driver and no direction.
// RULE8: Each bidirectional port bit has its own direction control.
// RULE9: Pulse outputs share port C bits 1 and 2, selected per pin.
// RULE10: External counter clock on port 9 bit 4 stays below 1 MHz.
// RULE11: Eight converter channels share port 6 and 9 pins, per-pin switch.
// RULE12: Port 6 bits 0 and 1 free for port use in resistor or internal modes.
// RULE13: Resistor oscillator clock taken from the loop filter capacitor pin.
// RULE14: Address 0 accesses the location pointed to by the RAM select register.
// RULE15: Status bits 7:6 select which special page decodes addresses 5 to E; the code pages only 5 to D, and E is flag A on every page.
// RULE16: Status bit 5 selects control page 0 or 1 for addresses 5 to E; the code pages only 5 to D, and E is mask A on both pages.
// RULE17: RAM select bits 7:6 pick the bank; bits 5:0 form indirect address.
// RULE18: Unassigned addresses ignore writes and read an undefined value.
package psr_pkg;
   localparam logic [5:0] ADDR_INDIRECT = 6'h00;
   localparam logic [5:0] ADDR_RTC = 6'h01;
   localparam logic [5:0] ADDR_PCL = 6'h02;
   localparam logic [5:0] ADDR_STATUS = 6'h03;
   localparam logic [5:0] ADDR_RAMSEL = 6'h04;
   localparam logic [5:0] ADDR_R5 = 6'h05;
   localparam logic [5:0] ADDR_R6 = 6'h06;
   localparam logic [5:0] ADDR_R7 = 6'h07;
   localparam logic [5:0] ADDR_R8 = 6'h08;
   localparam logic [5:0] ADDR_R9 = 6'h09;
   localparam logic [5:0] ADDR_RA = 6'h0a;
   localparam logic [5:0] ADDR_RB = 6'h0b;
   localparam logic [5:0] ADDR_RC = 6'h0c;
   localparam logic [5:0] ADDR_RD = 6'h0d;
   localparam logic [5:0] ADDR_FLAGA = 6'h0e;
   localparam logic [5:0] ADDR_FLAGB = 6'h0f;
   localparam logic [5:0] ADDR_GLOBAL_LO = 6'h10;
   localparam logic [5:0] ADDR_BANK_LO = 6'h20;
   localparam logic [3:0] PAGED_LO = 4'h5;
   localparam logic [3:0] PAGED_HI = 4'he;
   // Field positions
   localparam int STAT_PAGE_HI = 7;
   localparam int STAT_PAGE_LO = 6;
   localparam int STAT_CPAGE = 5;
   localparam int RSEL_BANK_HI = 7;
   localparam int RSEL_BANK_LO = 6;
   localparam int PULSE_OUTPUT_ONE_EN_BIT = 6;
   localparam int PULSE_OUTPUT_TWO_EN_BIT = 7;
   localparam int EDGE_SEL_BIT = 0;
   localparam int FLAG_EDGE_BIT = 0;
   localparam int FLAG_GROUP_BIT = 1;
   localparam int OSC_MODE_LO = 0;
   // Reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [7:0] RST_DIR = 8'hff;
   // Oscillator mode encoding in clock control bits 1:0
   localparam logic [1:0] OSC_CRYSTAL = 2'h0;
   localparam logic [1:0] OSC_RESISTOR = 2'h1;
   localparam logic [1:0] OSC_INTERNAL = 2'h2;
   // Counter clock limit and rate
   localparam int CLK_HZ = 25000000;
   localparam int CNT_EXT_MAX_HZ = 1000000;
   localparam int CNT_EXT_MIN_CYC = CLK_HZ / CNT_EXT_MAX_HZ;

   typedef struct packed {
      logic wr;
      logic rd;
      logic ctlWr;
      logic ctlRd;
      logic [5:0] addr;
      logic [7:0] wdata;
   } psr_req_t;

   typedef struct packed {
      logic [7:0] dout;
      logic [7:0] oe;
   } psr_pins_t;
endpackage : psr_pkg

/* File: rtl/psr_edge_det.sv */
// Purpose: Edge detector for one synchronous pin input
// Assumes: Input already synchronous to clk
// Notes: Pulse lasts one cycle
`timescale 1ns/1ns
module psr_edge_det (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Pin and polarity
   input wire logic pin,
   input wire logic rising,
   // Event
   output logic hit
);
   logic last;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         last <= 1'b1;
      end else begin
         last <= pin;
      end
   end

   always_comb begin
      hit = rising ? (pin & ~last) : (~pin & last);
   end
endmodule : psr_edge_det

/* File: rtl/psr_space.sv */
// Purpose: Paged special register, control register and RAM decode
// Assumes: Core issues at most one access strobe per cycle
// Notes: Read data is registered; it appears one cycle after the strobe
`timescale 1ns/1ns
module psr_space
   import psr_pkg::*;
#(
   parameter int GLOBAL_BYTES = 16,
   parameter int BANK_BYTES = 32,
   parameter int BANKS = 4
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Core access
   input wire psr_req_t req,
   output logic [7:0] rdata,
   // Port pins
   input wire logic [7:0] port6In,
   input wire logic [7:0] port7In,
   input wire logic [7:0] port9In,
   input wire logic [7:0] portcIn,
   output psr_pins_t port6Pins,
   output psr_pins_t port7Pins,
   output psr_pins_t port9Pins,
   output psr_pins_t portcPins,
   // Pulse outputs from peripheral
   input wire logic pulseOne,
   input wire logic pulseTwo,
   // Peripheral side
   input wire logic [7:0] convResultHigh,
   input wire logic [7:0] convResultBuf,
   output logic [7:0] convChannelSel,
   output logic resistorOscClk,
   output logic edgeIrq,
   output logic groupIrq,
   // Status core bits and program counter low byte
   input wire logic [4:0] statusCore,
   input wire logic [7:0] pcLow
);
   logic [7:0] status;
   logic [7:0] ramSel;
   logic [7:0] rtc;
   logic [7:0] romPage;
   logic [7:0] pwmCtl;
   logic [7:0] pwmReg [6:11];
   logic [7:0] p6Data, p7Data, p9Data, pcData;
   logic [7:0] p6Dir, p7Dir, p9Dir, pcDir;
   logic [7:0] p6Switch, p7Pull, convCtl, cnt1Val, cnt1Src, clkCtl;
   logic [7:0] flagA, flagB, maskA, maskB;
   logic [7:0] gram [GLOBAL_BYTES];
   logic [7:0] bram [BANKS*BANK_BYTES];
   logic [5:0] effAddr;
   logic [1:0] rpage;
   logic cpage;
   logic [1:0] bank;
   logic wrHit, ctlWrHit;
   logic [7:0] next_rdata;
   logic [7:0] next_flagA, next_flagB;
   logic edgeHit, in1Hit, in3Hit;
   logic [7:0] p6OeMask;

   assign rpage = status[STAT_PAGE_HI:STAT_PAGE_LO]; // RULE15
   assign cpage = status[STAT_CPAGE]; // RULE16
   assign bank = ramSel[RSEL_BANK_HI:RSEL_BANK_LO]; // RULE17
   // Address 0 redirects through the pointer bits
   assign effAddr = (req.addr == ADDR_INDIRECT) ? ramSel[5:0] : req.addr; // RULE14
   assign wrHit = req.wr;
   // Control space ends at 0F; higher addresses must not alias onto it
   assign ctlWrHit = req.ctlWr && (req.addr[5:4] == 2'b00); // RULE4

   function automatic logic isPaged(input logic [5:0] a);
      isPaged = (a[5:4] == 2'b00) && (a[3:0] >= PAGED_LO) && (a[3:0] <= PAGED_HI);
   endfunction : isPaged

   psr_edge_det uEdge0 (
      .clk(clk), .nrst(nrst), .pin(port7In[0]),
      .rising(cnt1Src[EDGE_SEL_BIT]), .hit(edgeHit)); // RULE5
   psr_edge_det uEdge1 (
      .clk(clk), .nrst(nrst), .pin(port7In[1]), .rising(1'b0), .hit(in1Hit)); // RULE6
   psr_edge_det uEdge3 (
      .clk(clk), .nrst(nrst), .pin(port7In[3]), .rising(1'b0), .hit(in3Hit)); // RULE6

   // Special registers on direct write
   always_ff @(posedge clk) begin
      if (!nrst) begin
         status <= RST_BYTE;
         ramSel <= RST_BYTE;
         rtc <= RST_BYTE;
         romPage <= RST_BYTE;
         pwmCtl <= RST_BYTE;
         p6Data <= RST_BYTE;
         p7Data <= RST_BYTE;
         p9Data <= RST_BYTE;
         pcData <= RST_BYTE;
         clkCtl <= RST_BYTE;
         cnt1Val <= RST_BYTE;
         for (int i = 6; i <= 11; i++) begin
            pwmReg[i] <= RST_BYTE;
         end
      end else if (wrHit) begin
         unique case (effAddr) // RULE1
            ADDR_RTC: rtc <= req.wdata;
            ADDR_STATUS: status <= {req.wdata[7:5], 5'h00};
            ADDR_RAMSEL: ramSel <= req.wdata;
            default: begin
               if (isPaged(effAddr)) begin
                  unique case (rpage)
                     2'd0: begin
                        if (effAddr == ADDR_R5) romPage <= req.wdata;
                        if (effAddr == ADDR_R6) p6Data <= req.wdata;
                        if (effAddr == ADDR_R7) p7Data <= req.wdata;
                        if (effAddr == ADDR_R9) p9Data <= req.wdata;
                        if (effAddr == ADDR_RA) clkCtl <= req.wdata;
                        if (effAddr == ADDR_RC) pcData <= req.wdata;
                     end
                     2'd1: begin
                        if (effAddr == ADDR_RC) cnt1Val <= req.wdata;
                     end
                     2'd2: begin
                        // Page 2 holds nothing
                     end
                     2'd3: begin
                        if (effAddr == ADDR_R5) pwmCtl <= req.wdata;
                        if (effAddr >= ADDR_R6 && effAddr <= ADDR_RB) begin
                           pwmReg[effAddr[3:0]] <= req.wdata;
                        end
                     end
                  endcase
               end
               // Other unassigned locations drop the write
            end // RULE18
         endcase
      end
   end

   // Global and banked RAM
   always_ff @(posedge clk) begin
      if (wrHit && effAddr[5:4] == 2'b01) begin
         gram[effAddr[3:0]] <= req.wdata; // RULE2
      end
      if (wrHit && effAddr[5]) begin
         bram[{bank, effAddr[4:0]}] <= req.wdata; // RULE3
      end
   end

   // Control register space
   always_ff @(posedge clk) begin
      if (!nrst) begin
         p6Dir <= RST_DIR;
         p7Dir <= RST_DIR;
         p9Dir <= RST_DIR;
         pcDir <= RST_DIR;
         p6Switch <= RST_BYTE;
         p7Pull <= RST_BYTE;
         convCtl <= RST_BYTE;
         cnt1Src <= RST_BYTE;
         maskA <= RST_BYTE;
         maskB <= RST_BYTE;
      end else if (ctlWrHit) begin
         unique case ({cpage, req.addr[3:0]}) // RULE16
            {1'b0, ADDR_R6[3:0]}: p6Dir <= req.wdata; // RULE8
            {1'b0, ADDR_R7[3:0]}: p7Dir <= req.wdata;
            {1'b0, ADDR_R9[3:0]}: p9Dir <= req.wdata;
            {1'b0, ADDR_RC[3:0]}: pcDir <= req.wdata;
            {1'b1, ADDR_R6[3:0]}: p6Switch <= req.wdata;
            {1'b1, ADDR_R7[3:0]}: p7Pull <= req.wdata;
            {1'b1, ADDR_RB[3:0]}: convCtl <= req.wdata;
            {1'b1, ADDR_RD[3:0]}: cnt1Src <= req.wdata;
            default: begin
               if (req.addr == ADDR_FLAGA) maskA <= req.wdata;
               if (req.addr == ADDR_FLAGB) maskB <= req.wdata;
            end // RULE18
         endcase
      end
   end

   // Interrupt flags; a new event wins over a software clear
   always_comb begin
      next_flagA = flagA;
      next_flagB = flagB;
      if (wrHit && effAddr == ADDR_FLAGA) begin
         next_flagA = req.wdata;
      end
      if (wrHit && effAddr == ADDR_FLAGB) begin
         next_flagB = req.wdata;
      end
      next_flagA[FLAG_EDGE_BIT] = next_flagA[FLAG_EDGE_BIT] | edgeHit; // RULE5
      next_flagA[FLAG_GROUP_BIT] = next_flagA[FLAG_GROUP_BIT] | in1Hit | in3Hit; // RULE6
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         flagA <= RST_BYTE;
         flagB <= RST_BYTE;
      end else begin
         flagA <= next_flagA;
         flagB <= next_flagB;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         edgeIrq <= 1'b0;
         groupIrq <= 1'b0;
      end else begin
         edgeIrq <= flagA[FLAG_EDGE_BIT] & maskA[FLAG_EDGE_BIT];
         groupIrq <= flagA[FLAG_GROUP_BIT] & maskA[FLAG_GROUP_BIT];
      end
   end

   // Read mux
   always_comb begin
      next_rdata = 8'h00; // RULE18
      if (req.rd) begin
         if (effAddr[5]) begin
            next_rdata = bram[{bank, effAddr[4:0]}]; // RULE3
         end else if (effAddr[4]) begin
            next_rdata = gram[effAddr[3:0]]; // RULE2
         end else begin
            unique case (effAddr)
               ADDR_RTC: next_rdata = rtc;
               ADDR_PCL: next_rdata = pcLow;
               ADDR_STATUS: next_rdata = {status[7:5], statusCore};
               ADDR_RAMSEL: next_rdata = ramSel;
               ADDR_FLAGA: next_rdata = flagA;
               ADDR_FLAGB: next_rdata = flagB;
               default: begin
                  unique case (rpage) // RULE1
                     2'd0: begin
                        if (effAddr == ADDR_R5) next_rdata = romPage;
                        if (effAddr == ADDR_R6) next_rdata = port6In;
                        if (effAddr == ADDR_R7) next_rdata = port7In;
                        if (effAddr == ADDR_R9) next_rdata = port9In;
                        if (effAddr == ADDR_RA) next_rdata = clkCtl;
                        if (effAddr == ADDR_RC) next_rdata = portcIn;
                     end
                     2'd1: begin
                        if (effAddr == ADDR_R7) next_rdata = convResultHigh;
                        if (effAddr == ADDR_RB) next_rdata = convResultBuf;
                        if (effAddr == ADDR_RC) next_rdata = cnt1Val;
                     end
                     2'd2: next_rdata = 8'h00;
                     2'd3: begin
                        if (effAddr == ADDR_R5) next_rdata = pwmCtl;
                        if (effAddr >= ADDR_R6 && effAddr <= ADDR_RB) begin
                           next_rdata = pwmReg[effAddr[3:0]];
                        end
                     end
                  endcase
               end
            endcase
         end
      end else if (req.ctlRd && req.addr[5:4] == 2'b00) begin // RULE4
         unique case ({cpage, req.addr[3:0]})
            {1'b0, ADDR_R6[3:0]}: next_rdata = p6Dir;
            {1'b0, ADDR_R7[3:0]}: next_rdata = p7Dir;
            {1'b0, ADDR_R9[3:0]}: next_rdata = p9Dir;
            {1'b0, ADDR_RC[3:0]}: next_rdata = pcDir;
            {1'b1, ADDR_R6[3:0]}: next_rdata = p6Switch;
            {1'b1, ADDR_R7[3:0]}: next_rdata = p7Pull;
            {1'b1, ADDR_RB[3:0]}: next_rdata = convCtl;
            {1'b1, ADDR_RD[3:0]}: next_rdata = cnt1Src;
            default: begin
               if (req.addr == ADDR_FLAGA) next_rdata = maskA;
               if (req.addr == ADDR_FLAGB) next_rdata = maskB;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         rdata <= RST_BYTE;
      end else begin
         rdata <= next_rdata;
      end
   end

   // Port 6 bits 0,1 usable in every oscillator mode except crystal
   always_comb begin
      p6OeMask = 8'hff;
      if (clkCtl[OSC_MODE_LO+1:OSC_MODE_LO] == OSC_CRYSTAL) begin
         p6OeMask[1:0] = 2'b00; // RULE12
      end
      // Converter channels on port 6 bits 2..5 released from the port
      p6OeMask[5:2] = ~p6Switch[5:2]; // RULE11
   end

   // Port 6 and port 9 drivers, direction bit 1 means input
   always_ff @(posedge clk) begin
      if (!nrst) begin
         port6Pins <= '0;
         port9Pins <= '0;
      end else begin
         port6Pins.dout <= p6Data;
         port6Pins.oe <= ~p6Dir & p6OeMask; // RULE8
         port9Pins.dout <= p9Data;
         port9Pins.oe <= ~p9Dir & ~{4'h0, p6Switch[7:6], p6Switch[1:0]}; // RULE11
      end
   end

   // Port 7 drivers; bit 1 never driven
   always_ff @(posedge clk) begin
      if (!nrst) begin
         port7Pins <= '0;
      end else begin
         port7Pins.dout <= {p7Data[7:2], 1'b0, p7Data[0]};
         port7Pins.oe <= {~p7Dir[7:2], 1'b0, ~p7Dir[0]}; // RULE7
      end
   end

   // Port C drivers; bits 1 and 2 go to the pulse outputs when enabled
   always_ff @(posedge clk) begin
      if (!nrst) begin
         portcPins <= '0;
      end else begin
         portcPins.dout <= {pcData[7:3],
                            pwmCtl[PULSE_OUTPUT_TWO_EN_BIT] ? pulseTwo : pcData[2],
                            pwmCtl[PULSE_OUTPUT_ONE_EN_BIT] ? pulseOne : pcData[1],
                            pcData[0]}; // RULE9
         portcPins.oe <= {~pcDir[7:3],
                          pwmCtl[PULSE_OUTPUT_TWO_EN_BIT] | ~pcDir[2],
                          pwmCtl[PULSE_OUTPUT_ONE_EN_BIT] | ~pcDir[1],
                          ~pcDir[0]}; // RULE9
      end
   end

   // Channels 1,2,7,8 on port 9 bits 0-3, channels 3-6 on port 6 bits 2-5
   always_ff @(posedge clk) begin
      if (!nrst) begin
         convChannelSel <= RST_BYTE;
      end else begin
         convChannelSel <= p6Switch; // RULE11
      end
   end

   // Capacitor pin doubles as the resistor oscillator clock input
   always_ff @(posedge clk) begin
      if (!nrst) begin
         resistorOscClk <= 1'b0;
      end else begin
         resistorOscClk <= (clkCtl[OSC_MODE_LO+1:OSC_MODE_LO] == OSC_RESISTOR)
                           ? port7In[0] : 1'b0; // RULE13
      end
   end
endmodule : psr_space

/* File: test/psr_space_chk.sv */
// Purpose: Port checks of the paged register space
// Assumes: One clock, synchronous active-low reset
// Notes: Bound onto psr_space
`timescale 1ns/1ns
module psr_space_chk
   import psr_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Core side
   input wire psr_req_t req,
   input wire logic [7:0] rdata,
   input wire logic [7:0] pcLow,
   // Pins and events
   input wire logic [7:0] port7In,
   input wire psr_pins_t port7Pins,
   input wire psr_pins_t port9Pins,
   input wire logic [7:0] convChannelSel,
   input wire logic resistorOscClk,
   input wire logic edgeIrq,
   input wire logic groupIrq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   a_rdata_idle_zero: assert property (!req.rd && !req.ctlRd |=> rdata == 8'h00)
      else $error("read data not zero without a read");
   a_pcl_readback: assert property (req.rd && req.addr == ADDR_PCL |=> rdata == $past(pcLow))
      else $error("program counter low not returned");
   a_global_ram: assert property (req.wr && req.addr[5:4] == 2'b01
      ##1 req.rd && req.addr == $past(req.addr) |=> rdata == $past(req.wdata, 2))
      else $error("global byte not read back");
   a_input_only_bit: assert property (port7Pins.oe[1] == 1'b0)
      else $error("input-only bit driven");
   a_dir_ctl_only: assert property ($changed(port9Pins.oe) |-> $past(req.ctlWr) || $past(req.ctlWr, 2))
      else $error("direction changed without control write");
   a_switch_ctl_only: assert property ($changed(convChannelSel) |-> $past(req.ctlWr) || $past(req.ctlWr, 2))
      else $error("channel select changed without control write");
   a_osc_follows: assert property ($rose(resistorOscClk) |-> $past(port7In[0]) || $past(port7In[0], 2))
      else $error("oscillator clock rose without pin");
   a_edge_irq_hold: assert property ($fell(edgeIrq) |-> $past(req.wr) || $past(req.ctlWr)
      || $past(req.wr, 2) || $past(req.ctlWr, 2))
      else $error("edge interrupt dropped without write");
   a_group_irq_hold: assert property ($fell(groupIrq) |-> $past(req.wr) || $past(req.ctlWr)
      || $past(req.wr, 2) || $past(req.ctlWr, 2))
      else $error("group interrupt dropped without write");
endmodule : psr_space_chk

bind psr_space psr_space_chk i_chk (.clk(clk), .nrst(nrst), .req(req), .rdata(rdata),
   .pcLow(pcLow), .port7In(port7In), .port7Pins(port7Pins), .port9Pins(port9Pins),
   .convChannelSel(convChannelSel), .resistorOscClk(resistorOscClk), .edgeIrq(edgeIrq),
   .groupIrq(groupIrq));

/* File: test/psr_core_model.sv */
// Purpose: Core model issuing move and control-space accesses
// Assumes: Called at a falling edge
// Notes: Idle bus shows inverted last address and data
`timescale 1ns/1ns
module psr_core_model
   import psr_pkg::*;
(
   // Clock
   input wire logic clk,
   // Core access
   output psr_req_t req,
   input wire logic [7:0] rdata
);
   initial req = '0;
   // Kind bits: move write, move read, control write, control read
   task automatic acc(input logic [3:0] k, input logic [5:0] a, input logic [7:0] d,
         input logic hold, output logic [7:0] q);
      req <= '{wr: k[3], rd: k[2], ctlWr: k[1], ctlRd: k[0], addr: a, wdata: d};
      @(negedge clk);
      q = rdata;
      if (!hold) begin
         req <= '{wr: 1'b0, rd: 1'b0, ctlWr: 1'b0, ctlRd: 1'b0, addr: ~a, wdata: ~d};
         @(negedge clk);
      end
   endtask : acc
endmodule : psr_core_model

/* File: test/paged_special_register_space_test.sv */
// Purpose: Self-checking bench of the paged register space
// Assumes: Inputs change at the falling edge
// Notes: Core accesses come from psr_core_model
`timescale 1ns/1ns
module paged_special_register_space_test;
   import psr_pkg::*;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   psr_req_t req;
   psr_pins_t port6Pins, port7Pins, port9Pins, portcPins;
   logic [7:0] rdata, rbyte, convChannelSel;
   logic resistorOscClk, edgeIrq, groupIrq;
   logic [7:0] port7In = 8'hff;
   logic [7:0] port6In = 8'h00;
   logic [7:0] port9In = 8'h00;
   logic pulseOne = 1'b0;
   logic pulseTwo = 1'b0;
   int errors = 0;
   int compares = 0;
   int cycles = 0;
   always #20 clk = ~clk;
   psr_space i_dut (.clk(clk), .nrst(nrst), .req(req), .rdata(rdata), .port6In(port6In),
      .port7In(port7In), .port9In(port9In), .portcIn(8'h00), .port6Pins(port6Pins),
      .port7Pins(port7Pins), .port9Pins(port9Pins), .portcPins(portcPins),
      .pulseOne(pulseOne), .pulseTwo(pulseTwo), .convResultHigh(8'h9d),
      .convResultBuf(8'h4e), .convChannelSel(convChannelSel),
      .resistorOscClk(resistorOscClk), .edgeIrq(edgeIrq), .groupIrq(groupIrq),
      .statusCore(5'h15), .pcLow(8'h3a));
   psr_core_model i_core (.clk(clk), .req(req), .rdata(rdata));
   task automatic test_done;
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : test_done
   always @(posedge clk) begin
      cycles++;
      if (cycles == 4000) begin
         errors++;
         test_done();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("mismatch %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      i_core.acc(4'h8, a, d, 1'b0, rbyte);
   endtask : wr
   task automatic rd(input logic [5:0] a, input logic [7:0] e);
      i_core.acc(4'h4, a, 8'h00, 1'b0, rbyte);
      chk(rbyte, e);
   endtask : rd
   task automatic cw(input logic [5:0] a, input logic [7:0] d);
      i_core.acc(4'h2, a, d, 1'b0, rbyte);
   endtask : cw
   task automatic cr(input logic [5:0] a, input logic [7:0] e);
      i_core.acc(4'h1, a, 8'h00, 1'b0, rbyte);
      chk(rbyte, e);
   endtask : cr
   task automatic setpg(input logic [1:0] pg, input logic cp);
      wr(ADDR_STATUS, {pg, cp, 5'h00});
   endtask : setpg
   task automatic pause;
      repeat (2) @(negedge clk);
   endtask : pause
   task automatic wirq(input int i, input logic e);
      int n;
      logic [1:0] v;
      for (n = 0; n < 6; n++) begin
         @(negedge clk);
         v = {groupIrq, edgeIrq};
         if (e && v[i]) break;
      end
      chk({7'h00, v[i]}, {7'h00, e});
   endtask : wirq
   task automatic t_banks;
      int b;
      for (b = 0; b < 4; b++) begin
         wr(ADDR_RAMSEL, {b[1:0], 6'h00});
         wr(6'h25, 8'ha0 + 8'(b));
      end
      for (b = 3; b >= 0; b--) begin
         wr(ADDR_RAMSEL, {b[1:0], 6'h00});
         rd(6'h25, 8'ha0 + 8'(b));
      end
      i_core.acc(4'h8, 6'h13, 8'h77, 1'b1, rbyte);
      rd(6'h13, 8'h77);
      wr(ADDR_RAMSEL, 8'hc0);
      rd(6'h13, 8'h77);
      wr(ADDR_RAMSEL, 8'ha5);
      rd(ADDR_INDIRECT, 8'ha2);
      wr(ADDR_INDIRECT, 8'h5a);
      rd(6'h25, 8'h5a);
      $display("t_banks done");
   endtask : t_banks
   task automatic t_pages;
      setpg(2'h3, 1'b0);
      wr(ADDR_R8, 8'h3c);
      rd(ADDR_R8, 8'h3c);
      setpg(2'h2, 1'b0);
      wr(ADDR_R8, 8'hff);
      rd(ADDR_R8, 8'h00);
      setpg(2'h3, 1'b0);
      rd(ADDR_R8, 8'h3c);
      setpg(2'h1, 1'b1);
      rd(ADDR_R7, 8'h9d);
      rd(ADDR_RB, 8'h4e);
      rd(ADDR_STATUS, 8'h75);
      rd(ADDR_PCL, 8'h3a);
      $display("t_pages done");
   endtask : t_pages
   task automatic t_ctl;
      setpg(2'h0, 1'b0);
      port6In = 8'h2c;
      port9In = 8'h10;
      rd(ADDR_R6, 8'h2c);
      rd(ADDR_R9, 8'h10);
      // Counter clock pin held a full minimum period before it moves
      repeat (CNT_EXT_MIN_CYC) @(negedge clk);
      port9In = 8'h00;
      rd(ADDR_R9, 8'h00);
      cw(ADDR_R9, 8'h0f);
      cw(6'h19, 8'hff);
      wr(ADDR_R9, 8'ha5);
      pause;
      chk(port9Pins.oe, 8'hf0);
      chk(port9Pins.dout & 8'hf0, 8'ha0);
      cr(ADDR_R9, 8'h0f);
      cw(ADDR_R7, 8'h00);
      pause;
      chk({6'h00, port7Pins.oe[1:0]}, 8'h01);
      cw(ADDR_R7, 8'hff);
      cw(ADDR_R9, 8'hff);
      setpg(2'h0, 1'b1);
      cr(ADDR_R9, 8'h00);
      cw(ADDR_R6, 8'h0c);
      pause;
      chk(convChannelSel, 8'h0c);
      cw(ADDR_R6, 8'h00);
      $display("t_ctl done");
   endtask : t_ctl
   task automatic t_pwm;
      setpg(2'h3, 1'b0);
      wr(ADDR_R5, 8'hc0);
      pulseOne = 1'b1;
      pause;
      chk({4'h0, portcPins.oe[2:1], portcPins.dout[2:1]}, 8'h0d);
      pulseOne = 1'b0;
      pulseTwo = 1'b1;
      pause;
      chk({4'h0, portcPins.oe[2:1], portcPins.dout[2:1]}, 8'h0e);
      wr(ADDR_R5, 8'h00);
      pause;
      chk({6'h00, portcPins.oe[2:1]}, 8'h00);
      $display("t_pwm done");
   endtask : t_pwm
   task automatic t_osc;
      setpg(2'h0, 1'b0);
      wr(ADDR_RA, 8'h01);
      cw(ADDR_R6, 8'hfc);
      pause;
      chk({6'h00, port6Pins.oe[1:0]}, 8'h03);
      port7In[0] = 1'b0;
      pause;
      chk({7'h00, resistorOscClk}, 8'h00);
      port7In[0] = 1'b1;
      pause;
      chk({7'h00, resistorOscClk}, 8'h01);
      wr(ADDR_RA, {6'h00, OSC_INTERNAL});
      pause;
      chk({6'h00, port6Pins.oe[1:0]}, 8'h03);
      chk({7'h00, resistorOscClk}, 8'h00);
      wr(ADDR_RA, 8'h00);
      pause;
      chk({6'h00, port6Pins.oe[1:0]}, 8'h00);
      cw(ADDR_R6, 8'hff);
      $display("t_osc done");
   endtask : t_osc
   task automatic t_irq;
      wr(ADDR_FLAGA, 8'h00);
      cw(ADDR_FLAGA, 8'h03);
      wirq(0, 1'b0);
      port7In[0] = 1'b0;
      wirq(0, 1'b1);
      wr(ADDR_FLAGA, 8'h00);
      wirq(0, 1'b0);
      port7In[0] = 1'b1;
      wirq(0, 1'b0);
      setpg(2'h0, 1'b1);
      cw(ADDR_RD, 8'h01);
      setpg(2'h0, 1'b0);
      port7In[0] = 1'b0;
      wirq(0, 1'b0);
      port7In[0] = 1'b1;
      wirq(0, 1'b1);
      port7In[1] = 1'b0;
      wirq(1, 1'b1);
      wr(ADDR_FLAGA, 8'h00);
      wirq(1, 1'b0);
      port7In[3] = 1'b0;
      wirq(1, 1'b1);
      $display("t_irq done");
   endtask : t_irq
   initial begin
      repeat (3) @(negedge clk);
      nrst = 1'b1;
      t_banks();
      t_pages();
      t_ctl();
      t_pwm();
      t_osc();
      t_irq();
      test_done();
   end
endmodule : paged_special_register_space_test
